/* hw/tfc_defines.vh */
`ifndef TFC_DEFINES_VH
`define TFC_DEFINES_VH
// register byte offsets
`define TFC_OFF_TX_CFG      12'h408
`define TFC_OFF_FC_CFG      12'h40c
`define TFC_OFF_PAUSE_LO    12'h420
`define TFC_OFF_PAUSE_HI    12'h424
`define TFC_OFF_PAUSE_TX    12'h428
`define TFC_OFF_GAP_EXT     12'h42c
`define TFC_OFF_STATUS      12'h430
// mac_transmit_config fields
`define TFC_TX_RST_BIT      31
`define TFC_TX_FCS_BIT      29
`define TFC_TX_EN_BIT       28
`define TFC_TX_VLAN_BIT     27
`define TFC_TX_HD_BIT       26
`define TFC_TX_IFG_BIT      25
`define TFC_TX_TS_BIT       22
// pause_flow_config fields
`define TFC_FC_TX_BIT       30
`define TFC_FC_RX_BIT       29
// status fields
`define TFC_ST_BUSY_BIT     0
`define TFC_ST_PAUSED_BIT   1
`define TFC_ST_FCSERR_BIT   2
`define TFC_ST_VLANERR_BIT  3
// reset values
`define TFC_TX_CFG_RST      6'h0a
`define TFC_FC_CFG_RST      2'b11
`define TFC_PAUSE_ADDR_RST  48'hffee_ddcc_bbaa
`define TFC_GAP_EXT_RST     8'h0c
// frame constants
`define TFC_MIN_IFG         8'h0c
`define TFC_PRE_LAST        4'h7
`define TFC_PRE_BYTE        8'h55
`define TFC_SFD_BYTE        8'hd5
`define TFC_FCS_LAST        4'h3
`define TFC_PAUSE_LAST      16'h003b
`define TFC_VLAN_IDX_HI     16'h000c
`define TFC_VLAN_IDX_LO     16'h000d
`define TFC_VLAN_TAG_PROTOCOL_IDENTIFIER       16'h8100
`define TFC_QUANTUM_SHIFT   6
`define TFC_CRC_INIT        32'hffff_ffff
`define TFC_CRC_POLY        32'hedb8_8320
`define TFC_CRC_RESIDUE     32'hdebb_20e3
`endif

/* hw/tfc_crc32.v */
`timescale 1ns/10ps
`include "tfc_defines.vh"
module tfc_crc32 (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // control and data
  input  wire        init,
  input  wire        en,
  input  wire [7:0]  data,
  // running remainder
  output reg  [31:0] crc_reg
);
  function [31:0] crc_byte;
    input [31:0] c;
    input [7:0]  d;
    integer      i;
    reg   [31:0] r;
    begin
      r = c;
      for (i = 0; i < 8; i = i + 1) begin
        r = (r[0] ^ d[i]) ? ((r >> 1) ^ `TFC_CRC_POLY) : (r >> 1);
      end
      crc_byte = r;
    end
  endfunction

  always @(posedge clk_sys) begin
    if (!rst_n || init) begin
      crc_reg <= `TFC_CRC_INIT;
    end else if (en) begin
      crc_reg <= crc_byte(crc_reg, data); // see [R18]
    end
  end
endmodule

/* hw/tfc_ahb_slave.v */
`timescale 1ns/10ps
module tfc_ahb_slave (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // ahb-lite
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // register side
  output wire [11:0] rd_addr,
  input  wire [31:0] rd_data,
  output wire        wr_en,
  output wire [11:0] wr_addr,
  output wire [31:0] wr_data
);
  reg        wr_pend_reg;
  reg [11:0] wr_addr_reg;
  wire       take;

  // zero wait states; only word transfers are decoded
  assign take      = hsel && hready && htrans[1] && (hsize == 3'h2);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign rd_addr   = haddr[11:0];
  assign wr_en     = wr_pend_reg;
  assign wr_addr   = wr_addr_reg;
  assign wr_data   = hwdata;

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
      hrdata      <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= take && hwrite;
      if (take) begin
        wr_addr_reg <= haddr[11:0];
      end
      if (take && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end
endmodule

/* hw/tfc_tx_flow.v */
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`include "tfc_defines.vh"
// What this block does
// [R01] bit 29 set: frame data carries the check sequence; clear: block appends it
// [R02] every outgoing frame has its check sequence verified, whoever supplied it
// [R03] transmitter runs only while bit 28 is 1; resets to 0
// [R04] tagged frames go out only while bit 27 is 1; resets to 1
// [R05] a frame counts as tagged only for type field 0x8100
// [R06] software clears the basic tag enable when using extended tag mode
// [R07] software enables jumbo frames before using extended tag mode
// [R08] bit 26 picks half duplex; only full duplex works, keep it 0
// [R09] bit 25 set: gap stretched by extension value, never under 12 cycles
// [R10] bit 22 picks in-line timestamp command; ignored without timestamp support
// [R11] flow-control register writable any time, applied only in the gap
// [R12] with bit 30 set, writing pause transmit register sends a pause frame
// [R13] with bit 29 set, received pause frames hold off the transmitter
// [R14] with bit 29 clear, received pause frames are forwarded, no effect
// [R15] reserved bits of both registers read zero and ignore writes
// [R16] transmit config writable any time, applied in the gap; reset acts at once
// [R17] pause frames use the pause address as source and match it as destination
// [R18] check sequence is the standard 32-bit ethernet crc from address to pad
module tfc_tx_flow #(
  parameter TS_PRESENT = 1'b0
) (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // ahb-lite register bus
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // user transmit byte stream
  input  wire [7:0]  tx_data,
  input  wire        tx_valid,
  input  wire        tx_last,
  output wire        tx_ready,
  // received pause frame report
  input  wire        rx_ctrl_valid,
  input  wire [47:0] rx_ctrl_dst,
  input  wire [15:0] rx_ctrl_quanta,
  output reg         rx_ctrl_consume,
  output reg         rx_ctrl_forward,
  // phy transmit side
  output reg  [7:0]  phy_txd,
  output reg         phy_tx_en,
  output reg         phy_tx_er,
  // configuration seen by neighbours
  output wire        half_duplex_select,
  output wire        ts_cmd_inline
);
  localparam ST_IDLE = 3'h0;
  localparam ST_PRE  = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_FCS  = 3'h3;
  localparam ST_GAP  = 3'h4;

  // packed config: {fcs, en, vlan, hd, ifg, ts}
  reg  [5:0]  tx_cfg_reg, tx_act_reg;
  reg  [1:0]  fc_cfg_reg, fc_act_reg;
  reg  [47:0] pause_addr_reg;
  reg  [15:0] pause_quanta_reg;
  reg  [7:0]  gap_extension_value_reg;
  reg         pause_pend_reg;
  reg         fcs_err_reg, vlan_err_reg;
  reg  [2:0]  st_reg;
  reg  [15:0] cnt_reg;
  reg         src_pause_reg;
  reg         vlan_bad_reg;
  reg  [7:0]  tag_protocol_identifier_hi_reg;
  reg  [21:0] pause_cnt_reg;
  reg  [7:0]  byte_next;
  reg  [31:0] rd_data;
  wire [11:0] rd_addr, wr_addr;
  wire        wr_en;
  wire [31:0] wr_data;
  wire [31:0] crc_gen, crc_chk;
  wire        soft_rst, in_gap, user_beat, paused, start_user, data_done;
  wire [7:0]  gap_len;
  wire [15:0] cnt_inc;

  wire cfg_fcs  = tx_act_reg[5];
  wire cfg_en   = tx_act_reg[4];
  wire cfg_vlan = tx_act_reg[3];
  wire cfg_ifg  = tx_act_reg[1];

  function [7:0] pause_byte;
    input [15:0] idx;
    input [47:0] addr;
    input [15:0] quanta;
    begin
      case (idx)
        16'h0000: pause_byte = 8'h01;
        16'h0001: pause_byte = 8'h80;
        16'h0002: pause_byte = 8'hc2;
        16'h0005: pause_byte = 8'h01;
        16'h0006: pause_byte = addr[7:0];   // see [R17]
        16'h0007: pause_byte = addr[15:8];
        16'h0008: pause_byte = addr[23:16];
        16'h0009: pause_byte = addr[31:24];
        16'h000a: pause_byte = addr[39:32];
        16'h000b: pause_byte = addr[47:40];
        16'h000c: pause_byte = 8'h88;
        16'h000d: pause_byte = 8'h08;
        16'h000f: pause_byte = 8'h01;
        16'h0010: pause_byte = quanta[15:8];
        16'h0011: pause_byte = quanta[7:0];
        default:  pause_byte = 8'h00;
      endcase
    end
  endfunction

  tfc_ahb_slave u_bus (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_addr   (rd_addr),
    .rd_data   (rd_data),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  // generator sees the data phase only; checker also sees the appended sequence
  tfc_crc32 u_crc_gen (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .init    (st_reg == ST_PRE),
    .en      (st_reg == ST_DATA && (src_pause_reg || tx_valid)),
    .data    (byte_next),
    .crc_reg (crc_gen)
  );

  tfc_crc32 u_crc_chk (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .init    (st_reg == ST_PRE),
    .en      ((st_reg == ST_DATA && (src_pause_reg || tx_valid)) || st_reg == ST_FCS),
    .data    (byte_next),
    .crc_reg (crc_chk)
  );

  assign soft_rst   = wr_en && wr_addr == `TFC_OFF_TX_CFG && wr_data[`TFC_TX_RST_BIT];
  assign in_gap     = st_reg == ST_IDLE || st_reg == ST_GAP;
  assign paused     = pause_cnt_reg != 22'h000000;
  assign start_user = cfg_en && tx_valid && !(fc_act_reg[0] && paused); // see [R13]
  assign user_beat  = st_reg == ST_DATA && !src_pause_reg && tx_valid;
  assign tx_ready   = st_reg == ST_DATA && !src_pause_reg;             // see [R03]
  assign data_done  = src_pause_reg ? (cnt_reg == `TFC_PAUSE_LAST) : (tx_valid && tx_last);
  assign cnt_inc    = (cnt_reg == 16'hffff) ? cnt_reg : cnt_reg + 16'h0001;
  // stretch only above the minimum; a small extension value leaves 12 cycles
  assign gap_len    = (cfg_ifg && gap_extension_value_reg > `TFC_MIN_IFG) ?
                      gap_extension_value_reg : `TFC_MIN_IFG;          // see [R09]
  assign half_duplex_select = tx_act_reg[2];                          // see [R08]
  assign ts_cmd_inline      = tx_act_reg[0] & (TS_PRESENT != 0);      // see [R10]

  always @* begin
    byte_next = 8'h00;
    case (st_reg)
      ST_PRE:  byte_next = (cnt_reg[3:0] == `TFC_PRE_LAST) ? `TFC_SFD_BYTE : `TFC_PRE_BYTE;
      ST_DATA: byte_next = src_pause_reg ? pause_byte(cnt_reg, pause_addr_reg, pause_quanta_reg) : tx_data;
      ST_FCS: begin
        case (cnt_reg[1:0])
          2'h0:    byte_next = ~crc_gen[7:0];    // see [R01]
          2'h1:    byte_next = ~crc_gen[15:8];
          2'h2:    byte_next = ~crc_gen[23:16];
          default: byte_next = ~crc_gen[31:24];
        endcase
      end
      default: byte_next = 8'h00;
    endcase
  end

  // reserved positions are constant zero in every read path
  always @* begin
    rd_data = 32'h0000_0000;
    if (rd_addr == `TFC_OFF_TX_CFG) begin
      rd_data = {2'b00, tx_cfg_reg[5:1], 2'b00, tx_cfg_reg[0], 22'h000000}; // see [R15]
    end else if (rd_addr == `TFC_OFF_FC_CFG) begin
      rd_data = {1'b0, fc_cfg_reg, 29'h00000000};                          // see [R15]
    end else if (rd_addr == `TFC_OFF_PAUSE_LO) begin
      rd_data = pause_addr_reg[31:0];
    end else if (rd_addr == `TFC_OFF_PAUSE_HI) begin
      rd_data = {16'h0000, pause_addr_reg[47:32]};
    end else if (rd_addr == `TFC_OFF_PAUSE_TX) begin
      rd_data = {16'h0000, pause_quanta_reg};
    end else if (rd_addr == `TFC_OFF_GAP_EXT) begin
      rd_data = {24'h000000, gap_extension_value_reg};
    end else if (rd_addr == `TFC_OFF_STATUS) begin
      rd_data = {28'h0000000, vlan_err_reg, fcs_err_reg, paused, !in_gap};
    end
  end

  // register file; the transmitter reset bit is never stored
  always @(posedge clk_sys) begin
    if (!rst_n || soft_rst) begin
      tx_cfg_reg <= `TFC_TX_CFG_RST;                                    // see [R16]
    end else if (wr_en && wr_addr == `TFC_OFF_TX_CFG) begin
      tx_cfg_reg <= {wr_data[`TFC_TX_FCS_BIT], wr_data[`TFC_TX_EN_BIT], wr_data[`TFC_TX_VLAN_BIT],
                     wr_data[`TFC_TX_HD_BIT], wr_data[`TFC_TX_IFG_BIT], wr_data[`TFC_TX_TS_BIT]};
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fc_cfg_reg              <= `TFC_FC_CFG_RST;
      pause_addr_reg          <= `TFC_PAUSE_ADDR_RST;
      pause_quanta_reg        <= 16'h0000;
      gap_extension_value_reg <= `TFC_GAP_EXT_RST;
    end else if (wr_en) begin
      if (wr_addr == `TFC_OFF_FC_CFG) begin
        fc_cfg_reg <= {wr_data[`TFC_FC_TX_BIT], wr_data[`TFC_FC_RX_BIT]}; // see [R11]
      end else if (wr_addr == `TFC_OFF_PAUSE_LO) begin
        pause_addr_reg[31:0] <= wr_data;
      end else if (wr_addr == `TFC_OFF_PAUSE_HI) begin
        pause_addr_reg[47:32] <= wr_data[15:0];
      end else if (wr_addr == `TFC_OFF_PAUSE_TX) begin
        pause_quanta_reg <= wr_data[15:0];
      end else if (wr_addr == `TFC_OFF_GAP_EXT) begin
        gap_extension_value_reg <= wr_data[7:0];
      end
    end
  end

  // live copies change only between frames or on a transmitter reset, which also ends the frame, so a frame never sees a half update
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_act_reg <= `TFC_TX_CFG_RST;
      fc_act_reg <= `TFC_FC_CFG_RST;
    end else if (soft_rst) begin
      tx_act_reg <= `TFC_TX_CFG_RST;                                   // see [R16]
    end else if (in_gap) begin
      tx_act_reg <= tx_cfg_reg;                                        // see [R16]
      fc_act_reg <= fc_cfg_reg;                                        // see [R11]
    end
  end

  // pause request: the pause transmit register write set wins over the launch clear
  always @(posedge clk_sys) begin
    if (!rst_n || soft_rst) begin
      pause_pend_reg <= 1'b0;
    end else if (wr_en && wr_addr == `TFC_OFF_PAUSE_TX && fc_act_reg[1]) begin
      pause_pend_reg <= 1'b1;                                          // see [R12]
    end else if (st_reg == ST_IDLE && cfg_en) begin
      pause_pend_reg <= 1'b0;
    end
  end

  // received pause handling; quanta count in 64 byte times
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      pause_cnt_reg   <= 22'h000000;
      rx_ctrl_consume <= 1'b0;
      rx_ctrl_forward <= 1'b0;
    end else begin
      rx_ctrl_consume <= rx_ctrl_valid && fc_act_reg[0] && rx_ctrl_dst == pause_addr_reg;  // see [R17]
      rx_ctrl_forward <= rx_ctrl_valid && !(fc_act_reg[0] && rx_ctrl_dst == pause_addr_reg); // see [R14]
      if (rx_ctrl_valid && fc_act_reg[0] && rx_ctrl_dst == pause_addr_reg) begin
        pause_cnt_reg <= {rx_ctrl_quanta, {`TFC_QUANTUM_SHIFT{1'b0}}};  // see [R13]
      end else if (!fc_act_reg[0]) begin
        pause_cnt_reg <= 22'h000000;                                   // see [R14]
      end else if (paused) begin
        pause_cnt_reg <= pause_cnt_reg - 22'h000001;
      end
    end
  end

  // sticky status; set wins over a write-one clear
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      fcs_err_reg  <= 1'b0;
      vlan_err_reg <= 1'b0;
    end else begin
      if (st_reg == ST_GAP && cnt_reg == 16'h0000 && crc_chk != `TFC_CRC_RESIDUE) begin
        fcs_err_reg <= 1'b1;                                           // see [R02]
      end else if (wr_en && wr_addr == `TFC_OFF_STATUS && wr_data[`TFC_ST_FCSERR_BIT]) begin
        fcs_err_reg <= 1'b0;
      end
      if (user_beat && cnt_reg == `TFC_VLAN_IDX_LO && !cfg_vlan &&
          {tag_protocol_identifier_hi_reg, tx_data} == `TFC_VLAN_TAG_PROTOCOL_IDENTIFIER) begin
        vlan_err_reg <= 1'b1;
      end else if (wr_en && wr_addr == `TFC_OFF_STATUS && wr_data[`TFC_ST_VLANERR_BIT]) begin
        vlan_err_reg <= 1'b0;
      end
    end
  end

  // transmit sequencer
  always @(posedge clk_sys) begin
    if (!rst_n || soft_rst) begin
      st_reg        <= ST_IDLE;
      cnt_reg       <= 16'h0000;
      src_pause_reg <= 1'b0;
      vlan_bad_reg  <= 1'b0;
      tag_protocol_identifier_hi_reg   <= 8'h00;
      phy_txd       <= 8'h00;
      phy_tx_en     <= 1'b0;
      phy_tx_er     <= 1'b0;
    end else begin
      phy_txd   <= byte_next;
      phy_tx_en <= st_reg == ST_PRE || st_reg == ST_DATA || st_reg == ST_FCS;
      phy_tx_er <= (st_reg == ST_DATA && !src_pause_reg && !tx_valid) ||
                   (vlan_bad_reg && (st_reg == ST_DATA || st_reg == ST_FCS));
      case (st_reg)
        ST_IDLE: begin
          cnt_reg      <= 16'h0000;
          vlan_bad_reg <= 1'b0;
          if (cfg_en && pause_pend_reg) begin                          // see [R03]
            src_pause_reg <= 1'b1;
            st_reg        <= ST_PRE;
          end else if (start_user) begin
            src_pause_reg <= 1'b0;
            st_reg        <= ST_PRE;
          end
        end
        ST_PRE: begin
          cnt_reg <= cnt_inc;
          if (cnt_reg[3:0] == `TFC_PRE_LAST) begin
            cnt_reg <= 16'h0000;
            st_reg  <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (src_pause_reg || tx_valid) begin
            cnt_reg <= cnt_inc;
            if (cnt_reg == `TFC_VLAN_IDX_HI) begin
              tag_protocol_identifier_hi_reg <= byte_next;
            end
            // a disallowed tag poisons the rest of the frame with error symbols
            if (!src_pause_reg && cnt_reg == `TFC_VLAN_IDX_LO && !cfg_vlan &&
                {tag_protocol_identifier_hi_reg, tx_data} == `TFC_VLAN_TAG_PROTOCOL_IDENTIFIER) begin
              vlan_bad_reg <= 1'b1;                                    // see [R04] see [R05]
            end
            if (data_done) begin
              cnt_reg <= 16'h0000;
              st_reg  <= (cfg_fcs && !src_pause_reg) ? ST_GAP : ST_FCS; // see [R01]
            end
          end
        end
        ST_FCS: begin
          cnt_reg <= cnt_inc;
          if (cnt_reg[1:0] == `TFC_FCS_LAST) begin
            cnt_reg <= 16'h0000;
            st_reg  <= ST_GAP;
          end
        end
        ST_GAP: begin
          cnt_reg <= cnt_inc;
          if (cnt_reg[7:0] == gap_len - 8'h01) begin                   // see [R09]
            cnt_reg <= 16'h0000;
            st_reg  <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

/* verification/tfc_checker.sv */
`timescale 1ns/10ps
module tfc_checker #(
  parameter TS_PRESENT = 1'b0
) (
  // clock and reset
  input wire        clk_sys,
  input wire        rst_n,
  // register bus
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  // user stream and pause report
  input wire        tx_ready,
  input wire        rx_ctrl_valid,
  input wire        rx_ctrl_consume,
  input wire        rx_ctrl_forward,
  // phy side
  input wire [7:0]  phy_txd,
  input wire        phy_tx_en,
  input wire        phy_tx_er,
  input wire        ts_cmd_inline
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wire       rd_req = hsel && hready && htrans[1] && !hwrite;
  reg  [4:0] idle_cnt_reg;

  // saturates so the first frame after reset never looks short of gap
  always @(posedge clk_sys) begin
    if (!rst_n)
      idle_cnt_reg <= 5'h1f;
    else if (phy_tx_en)
      idle_cnt_reg <= 5'h00;
    else if (idle_cnt_reg != 5'h1f)
      idle_cnt_reg <= idle_cnt_reg + 5'h01;
  end

  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  chk_tx_reserved: assert property (rd_req && haddr[11:0] == 12'h408 |=> (hrdata & 32'hc1bf_ffff) == 32'h0)
    else $error("tx config reserved bits not zero");
  chk_fc_reserved: assert property (rd_req && haddr[11:0] == 12'h40c |=> (hrdata & 32'h9fff_ffff) == 32'h0)
    else $error("flow config reserved bits not zero");
  chk_gap_min: assert property ($rose(phy_tx_en) |-> idle_cnt_reg >= 5'h0c)
    else $error("inter-frame gap under minimum");
  chk_ready_sfd: assert property ($rose(tx_ready) |-> phy_tx_en && phy_txd == 8'hd5 && $past(phy_txd, 7) == 8'h55)
    else $error("data phase not after preamble");
  chk_preamble_run: assert property ($rose(phy_tx_en) |-> (phy_txd == 8'h55)[*7] ##1 phy_txd == 8'hd5)
    else $error("preamble malformed");
  chk_er_framed: assert property (phy_tx_er |-> phy_tx_en)
    else $error("error flag outside frame");
  chk_pause_answer: assert property (rx_ctrl_valid |=> rx_ctrl_consume ^ rx_ctrl_forward)
    else $error("pause report not answered once");
  chk_pause_cause: assert property (rx_ctrl_consume || rx_ctrl_forward |-> $past(rx_ctrl_valid))
    else $error("pause answer without report");
  chk_ts_ignored: assert property (TS_PRESENT == 0 |-> !ts_cmd_inline)
    else $error("timestamp select without support");
endmodule

/* verification/tfc_phy_model.sv */
`timescale 1ns/10ps
module tfc_phy_model (
  // clock and reset
  input wire       clk_sys,
  input wire       rst_n,
  // mac transmit pins
  input wire [7:0] phy_txd,
  input wire       phy_tx_en,
  input wire       phy_tx_er
);
  reg [7:0]  fr [0:71];
  reg [31:0] crc;
  reg        er;
  reg        crc_ok;
  integer    n;
  integer    len;
  integer    gap;
  integer    idle;
  integer    frames;

  function [31:0] crc8(input [31:0] c, input [7:0] d);
    integer b;
    begin
      crc8 = c ^ {24'h0, d};
      for (b = 0; b < 8; b = b + 1)
        crc8 = crc8[0] ? (crc8 >> 1) ^ 32'hedb8_8320 : crc8 >> 1;
    end
  endfunction

  // a gmii receiver only listens, so there is nothing to stall or release
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      n = 0;
      idle = 0;
      frames = 0;
    end else if (phy_tx_en) begin
      if (n == 0) begin
        gap = idle;
        er = 1'b0;
        crc = 32'hffff_ffff;
      end
      if (n >= 8)
        crc = crc8(crc, phy_txd);
      if (n >= 8 && n < 80)
        fr[n - 8] = phy_txd;
      er = er | phy_tx_er;
      n = n + 1;
    end else begin
      if (n > 0) begin
        len = n - 8;
        crc_ok = (crc == 32'hdebb_20e3);
        frames = frames + 1;
        idle = 0;
      end
      n = 0;
      idle = idle + 1;
    end
  end
endmodule

/* verification/tfc_tx_flow_tb.sv */
`timescale 1ns/10ps
module tfc_tx_flow_tb;
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [2:0]  hsize = 3'h2;
  reg  [31:0] hwdata = 32'h0;
  reg  [7:0]  tx_data = 8'h0;
  reg         tx_valid = 1'b0;
  reg         tx_last = 1'b0;
  reg         rx_ctrl_valid = 1'b0;
  reg  [47:0] rx_ctrl_dst = 48'h0;
  reg  [15:0] rx_ctrl_quanta = 16'h0;
  wire        hready, hreadyout, hresp, tx_ready, rx_ctrl_consume, rx_ctrl_forward;
  wire        phy_tx_en, phy_tx_er, half_duplex_select, ts_cmd_inline;
  wire [31:0] hrdata;
  wire [7:0]  phy_txd;
  reg  [7:0]  fb [0:71];
  reg  [31:0] q;
  reg  [47:0] sa;
  integer     num_errors = 0;
  integer     compares = 0;
  integer     cyc = 0;
  integer     k;

  assign hready = hreadyout;
  always #10 clk_sys = ~clk_sys;

  tfc_tx_flow tfc_tx_flow_i (.*);
  tfc_phy_model tfc_phy_model_i (.*);

  task finish_test;
    begin
      if (num_errors == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end

  task chk(input string nm, input [47:0] s, input [47:0] e);
    begin
      compares = compares + 1;
      if (s !== e) begin
        num_errors = num_errors + 1;
        $display("mismatch %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask

  task ahb(input [11:0] a, input w, input [31:0] d, input [2:0] sz);
    begin
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= sz;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      @(posedge clk_sys);
      while (hreadyout !== 1'b1) @(posedge clk_sys);
      q = hrdata;
      // idle cycle: a read right behind a write data phase sees the old value
      @(posedge clk_sys);
    end
  endtask

  task wr(input [11:0] a, input [31:0] d);
    ahb(a, 1'b1, d, 3'h2);
  endtask

  task rd(input [11:0] a, input [31:0] m, input [31:0] e);
    begin
      ahb(a, 1'b0, 32'h0, 3'h2);
      chk($sformatf("reg %h", a), q & m, e);
    end
  endtask

  task fill(input [15:0] ty);
    begin
      for (k = 0; k < 72; k = k + 1) fb[k] = k[7:0];
      fb[12] = ty[15:8];
      fb[13] = ty[7:0];
    end
  endtask

  // valid stays up the whole frame; a hole would be sent as an error byte
  task send(input integer n);
    integer i;
    begin
      i = 0;
      tx_valid <= 1'b1;
      tx_data <= fb[0];
      tx_last <= (n == 1);
      while (i < n) begin
        @(negedge clk_sys);
        if (tx_ready === 1'b1) i = i + 1;
        @(posedge clk_sys);
        tx_data <= fb[i];
        tx_last <= (i == n - 1);
      end
      tx_valid <= 1'b0;
      @(posedge clk_sys);
    end
  endtask

  task fin(input integer f, input integer l, input e);
    begin
      repeat (400) if (tfc_phy_model_i.frames < f) @(posedge clk_sys);
      chk("frames", tfc_phy_model_i.frames, f);
      chk("tx er", tfc_phy_model_i.er, e);
      if (l > 0) begin
        chk("length", tfc_phy_model_i.len, l);
        chk("fcs ok", tfc_phy_model_i.crc_ok, 1);
      end
    end
  endtask

  task rxp(input [47:0] dst, input ec, input ef);
    begin
      rx_ctrl_dst <= dst;
      rx_ctrl_quanta <= 16'h1;
      rx_ctrl_valid <= 1'b1;
      @(posedge clk_sys);
      rx_ctrl_valid <= 1'b0;
      @(negedge clk_sys);
      chk("consume", rx_ctrl_consume, ec);
      chk("forward", rx_ctrl_forward, ef);
      @(posedge clk_sys);
    end
  endtask

  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(12'h408, 32'hffff_ffff, 32'h0a00_0000);
    rd(12'h40c, 32'hffff_ffff, 32'h6000_0000);
    wr(12'h408, 32'h7fff_ffff);
    rd(12'h408, 32'hffff_ffff, 32'h3e40_0000);
    chk("half duplex", half_duplex_select, 1);
    chk("ts inline", ts_cmd_inline, 0);
    wr(12'h40c, 32'h9fff_ffff);
    rd(12'h40c, 32'hffff_ffff, 32'h0);
    wr(12'h40c, 32'h1fff_ffff);
    rd(12'h40c, 32'hffff_ffff, 32'h0);
    rd(12'h500, 32'hffff_ffff, 32'h0);
    wr(12'h408, 32'h8000_0000);
    rd(12'h408, 32'hffff_ffff, 32'h0a00_0000);
    wr(12'h40c, 32'h6000_0000);
    fill(16'h0800);
    tx_valid <= 1'b1;
    tx_data <= fb[0];
    repeat (40) @(posedge clk_sys);
    chk("frames off", tfc_phy_model_i.frames, 0);
    wr(12'h408, 32'h1a00_0000);
    send(60);
    fin(1, 64, 0);
    wr(12'h42c, 32'h14);
    send(60);
    send(60);
    fin(3, 64, 0);
    chk("gap ext", tfc_phy_model_i.gap >= 20, 1);
    wr(12'h408, 32'h1800_0000);
    send(60);
    send(60);
    fin(5, 64, 0);
    chk("gap min", tfc_phy_model_i.gap >= 12 && tfc_phy_model_i.gap < 20, 1);
    fork
      send(60);
      begin
        repeat (30) @(posedge clk_sys);
        wr(12'h408, 32'h0);
      end
    join
    fin(6, 64, 0);
    wr(12'h408, 32'h3a00_0000);
    q = 32'hffff_ffff;
    for (k = 0; k < 60; k = k + 1) q = tfc_phy_model_i.crc8(q, fb[k]);
    for (k = 0; k < 4; k = k + 1) fb[60 + k] = ~q[8*k +: 8];
    send(64);
    fin(7, 64, 0);
    fb[63] = fb[63] ^ 8'h01;
    send(64);
    fin(8, 0, 0);
    chk("fcs bad", tfc_phy_model_i.crc_ok, 0);
    rd(12'h430, 32'h4, 32'h4);
    wr(12'h430, 32'h4);
    rd(12'h430, 32'h4, 32'h0);
    wr(12'h408, 32'h1a00_0000);
    fill(16'h8100);
    send(60);
    fin(9, 64, 0);
    wr(12'h408, 32'h1200_0000);
    send(60);
    fin(10, 0, 1);
    rd(12'h430, 32'h8, 32'h8);
    fill(16'h8101);
    send(60);
    fin(11, 64, 0);
    wr(12'h428, 32'h10);
    fin(12, 64, 0);
    for (k = 0; k < 6; k = k + 1) sa[8*k +: 8] = tfc_phy_model_i.fr[6 + k];
    chk("pause sa", sa, 48'hffee_ddcc_bbaa);
    wr(12'h40c, 32'h2000_0000);
    wr(12'h428, 32'h10);
    repeat (150) @(posedge clk_sys);
    chk("no pause", tfc_phy_model_i.frames, 12);
    rxp(48'hffee_ddcc_bbaa, 1'b1, 1'b0);
    rd(12'h430, 32'h2, 32'h2);
    repeat (70) @(posedge clk_sys);
    rd(12'h430, 32'h2, 32'h0);
    rxp(48'h0000_0000_0001, 1'b0, 1'b1);
    wr(12'h40c, 32'h0);
    rxp(48'hffee_ddcc_bbaa, 1'b0, 1'b1);
    rd(12'h430, 32'h2, 32'h0);
    finish_test;
  end
endmodule

bind tfc_tx_flow tfc_checker #(.TS_PRESENT(TS_PRESENT)) tfc_checker_i (.*);
